// ==== verilog/modem_link_status.sv ====
// Function
// - status register at 08h, resets to 00h
// - temp clear works only below alarm limit
// - override one forces fast i2c filter
// - override zero follows protocol speed filter
// - select or poll answer sets target flag
// - target flag set only in passive anticollision
// - field off clears target flag
// - cipher flag on encrypts card traffic
// - only successful authentication sets cipher flag
// - cipher flag defined only in reader mode
// - modem field codes idle/send/wait/receive
// - code 001 waits for start bit
// - code 010 transmit wait, optional field wait
// - transmit wait lasts programmed minimum
// - code 100 receive wait with minimum, field
//
// Design decision made here: the strobed register port.
module modem_link_status
    import modem_status_pkg::*;
#(
    parameter int CNT_W = WAIT_CNT_W
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic      [DATA_W-1:0] rd_data_o,
    // modem sequencing
    input  wire logic              cmd_active_i,
    input  wire logic              start_transmit_bit_i,
    input  wire logic              transmit_wait_for_field_i,
    input  wire logic              receive_wait_for_field_i,
    input  wire logic [CNT_W-1:0]  transmit_wait_time_i,
    input  wire logic [CNT_W-1:0]  receive_wait_time_i,
    input  wire logic              tx_done_i,
    input  wire logic              rx_frame_start_i,
    input  wire logic              rx_done_i,
    input  wire logic              rf_field_present_i,
    // target activation
    input  wire logic              anticoll_active_i,
    input  wire logic              passive_mode_i,
    input  wire logic              select_or_poll_answered_i,
    // cipher and reader mode
    input  wire logic              auth_success_i,
    input  wire logic              reader_card_mode_i,
    // temperature and i2c
    input  wire logic              temp_over_limit_i,
    input  wire logic              i2c_hs_protocol_i,
    // status outputs
    output logic [MODEM_W-1:0]     modem_state_code_o,
    output logic                   cipher_active_o,
    output logic                   encrypt_en_o,
    output logic                   target_activated_flag_o,
    output logic                   temp_error_o,
    output logic                   i2c_filter_fast_o,
    output logic                   irq_o
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    function automatic logic [2:0] code_of(input modem_state_t s);
        case (s)
            ST_IDLE:       code_of = CODE_IDLE;
            ST_WAIT_START: code_of = CODE_WAIT_START;
            ST_TX_WAIT:    code_of = CODE_TX_WAIT;
            ST_SENDING:    code_of = CODE_SENDING;
            ST_RX_WAIT:    code_of = CODE_RX_WAIT;
            ST_WAIT_DATA:  code_of = CODE_WAIT_DATA;
            ST_RECEIVING:  code_of = CODE_RECEIVING;
            default:       code_of = CODE_IDLE;
        endcase
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic              wr_status;
    logic              wr_irq_status;
    logic              wr_irq_mask;
    modem_state_t      state_q;
    modem_state_t      state_d;
    logic [CNT_W-1:0]  wait_cnt_q;
    logic              tx_wait_done;
    logic              rx_wait_done;
    logic              force_fast_q;
    logic              target_q;
    logic              target_set;
    logic              cipher_q;
    logic              cipher_set;
    logic              temp_err_q;
    logic              temp_set;
    logic              idle_event;
    logic [IRQ_W-1:0]  irq_status_q;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [IRQ_W-1:0]  irq_events;
    logic [DATA_W-1:0] status_view;
    logic [DATA_W-1:0] rd_data_d;

    assign wr_status     = wr_en_i && hit(addr_i, STATUS_ADDR);
    assign wr_irq_status = wr_en_i && hit(addr_i, IRQ_STATUS_ADDR);
    assign wr_irq_mask   = wr_en_i && hit(addr_i, IRQ_MASK_ADDR);

    // ----------------------------------------
    // modem state machine
    // ----------------------------------------
    assign tx_wait_done = (wait_cnt_q >= transmit_wait_time_i)
                          && (!transmit_wait_for_field_i || rf_field_present_i);
    assign rx_wait_done = (wait_cnt_q >= receive_wait_time_i)
                          && (!receive_wait_for_field_i || rf_field_present_i);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (cmd_active_i) begin
                    state_d = ST_WAIT_START;
                end
            end
            ST_WAIT_START: begin
                if (start_transmit_bit_i) begin
                    state_d = ST_TX_WAIT;
                end
            end
            ST_TX_WAIT: begin
                if (tx_wait_done) begin
                    state_d = ST_SENDING;
                end
            end
            ST_SENDING: begin
                if (tx_done_i) begin
                    state_d = ST_RX_WAIT;
                end
            end
            ST_RX_WAIT: begin
                if (rx_wait_done) begin
                    state_d = ST_WAIT_DATA;
                end
            end
            ST_WAIT_DATA: begin
                if (rx_frame_start_i) begin
                    state_d = ST_RECEIVING;
                end
            end
            ST_RECEIVING: begin
                if (rx_done_i) begin
                    state_d = ST_WAIT_START;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (!cmd_active_i) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    // minimum-time counter, restarts on every state change
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_cnt_q <= '0;
        end else if (ce_i) begin
            if (state_d != state_q) begin
                wait_cnt_q <= '0;
            end else if (wait_cnt_q != {CNT_W{1'b1}}) begin
                wait_cnt_q <= wait_cnt_q + 1'b1;
            end
        end
    end

    // live code, no latching
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            modem_state_code_o <= CODE_IDLE;
        end else if (ce_i) begin
            modem_state_code_o <= code_of(state_d);
        end
    end

    // ----------------------------------------
    // i2c filter override
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            force_fast_q <= STATUS_RESET[FORCE_FAST_BIT];
        end else if (ce_i && wr_status) begin
            force_fast_q <= wr_data_i[FORCE_FAST_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            i2c_filter_fast_o <= 1'b0;
        end else if (ce_i) begin
            i2c_filter_fast_o <= force_fast_q || i2c_hs_protocol_i;
        end
    end

    // ----------------------------------------
    // target activation
    // ----------------------------------------
    assign target_set = select_or_poll_answered_i && anticoll_active_i
                        && passive_mode_i;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            target_q <= STATUS_RESET[TARGET_BIT];
        end else if (ce_i) begin
            if (!rf_field_present_i) begin
                target_q <= 1'b0;
            end else if (target_set) begin
                target_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // cipher active flag
    // ----------------------------------------
    assign cipher_set = auth_success_i;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cipher_q <= STATUS_RESET[CIPHER_BIT];
        end else if (ce_i) begin
            if (cipher_set) begin
                cipher_q <= 1'b1;
            end else if (wr_status && !wr_data_i[CIPHER_BIT]) begin
                cipher_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            encrypt_en_o <= 1'b0;
        end else if (ce_i) begin
            encrypt_en_o <= cipher_q && reader_card_mode_i;
        end
    end

    // ----------------------------------------
    // temperature error latch
    // ----------------------------------------
    assign temp_set = temp_over_limit_i;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            temp_err_q <= 1'b0;
        end else if (ce_i) begin
            if (temp_set) begin
                temp_err_q <= 1'b1;
            end else if (wr_status && wr_data_i[TEMP_CLR_BIT]) begin
                temp_err_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // flag outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cipher_active_o         <= 1'b0;
            target_activated_flag_o <= 1'b0;
            temp_error_o            <= 1'b0;
        end else if (ce_i) begin
            cipher_active_o         <= cipher_q;
            target_activated_flag_o <= target_q;
            temp_error_o            <= temp_err_q;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    assign idle_event = (state_q != ST_IDLE) && (state_d == ST_IDLE);

    assign irq_events[IRQ_TARGET_BIT] = target_set && rf_field_present_i && !target_q;
    assign irq_events[IRQ_CIPHER_BIT] = cipher_set && !cipher_q;
    assign irq_events[IRQ_TEMP_BIT]   = temp_set && !temp_err_q;
    assign irq_events[IRQ_IDLE_BIT]   = idle_event;

    // set wins over write-one-to-clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_status_q <= IRQ_RESET[IRQ_W-1:0];
        end else if (ce_i) begin
            irq_status_q <= (irq_status_q & ~({IRQ_W{wr_irq_status}} & wr_data_i[IRQ_W-1:0]))
                            | irq_events;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_mask_q <= IRQ_RESET[IRQ_W-1:0];
        end else if (ce_i && wr_irq_mask) begin
            irq_mask_q <= wr_data_i[IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always_comb begin
        status_view                                  = '0;
        status_view[FORCE_FAST_BIT]                  = force_fast_q;
        status_view[TARGET_BIT]                      = target_q;
        status_view[CIPHER_BIT]                      = cipher_q;
        status_view[MODEM_LSB +: MODEM_W]            = code_of(state_q);
    end

    always_comb begin
        rd_data_d = UNMAPPED_DATA;
        if (rd_en_i) begin
            case (addr_i)
                STATUS_ADDR:     rd_data_d = status_view;
                IRQ_STATUS_ADDR: rd_data_d = {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
                IRQ_MASK_ADDR:   rd_data_d = {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
                default:         rd_data_d = UNMAPPED_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else if (ce_i) begin
            rd_data_o <= rd_data_d;
        end
    end

endmodule // modem_link_status

// ==== verilog/modem_status_pkg.sv ====
package modem_status_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int          ADDR_W           = 6;
    localparam int          DATA_W           = 8;
    localparam logic [5:0]  STATUS_ADDR      = 6'h08;
    localparam logic [5:0]  IRQ_STATUS_ADDR  = 6'h10;
    localparam logic [5:0]  IRQ_MASK_ADDR    = 6'h11;
    localparam logic [7:0]  STATUS_RESET     = 8'h00;
    localparam logic [7:0]  IRQ_RESET        = 8'h00;
    localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;

    // ----------------------------------------
    // status register fields
    // ----------------------------------------
    localparam int          TEMP_CLR_BIT     = 7;
    localparam int          FORCE_FAST_BIT   = 6;
    localparam int          RESERVED_BIT     = 5;
    localparam int          TARGET_BIT       = 4;
    localparam int          CIPHER_BIT       = 3;
    localparam int          MODEM_LSB        = 0;
    localparam int          MODEM_W          = 3;

    // ----------------------------------------
    // interrupt status / mask fields
    // ----------------------------------------
    localparam int          IRQ_TARGET_BIT   = 0;
    localparam int          IRQ_CIPHER_BIT   = 1;
    localparam int          IRQ_TEMP_BIT     = 2;
    localparam int          IRQ_IDLE_BIT     = 3;
    localparam int          IRQ_W            = 4;

    // ----------------------------------------
    // modem state codes
    // ----------------------------------------
    localparam logic [2:0]  CODE_IDLE        = 3'h0;
    localparam logic [2:0]  CODE_WAIT_START  = 3'h1;
    localparam logic [2:0]  CODE_TX_WAIT     = 3'h2;
    localparam logic [2:0]  CODE_SENDING     = 3'h3;
    localparam logic [2:0]  CODE_RX_WAIT     = 3'h4;
    localparam logic [2:0]  CODE_WAIT_DATA   = 3'h5;
    localparam logic [2:0]  CODE_RECEIVING   = 3'h6;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          WAIT_CNT_W       = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_START,
        ST_TX_WAIT,
        ST_SENDING,
        ST_RX_WAIT,
        ST_WAIT_DATA,
        ST_RECEIVING
    } modem_state_t;

endpackage

// ==== sim/modem_link_status_chk.sv ====
module modem_link_status_chk
    import modem_status_pkg::*;
#(
    parameter int CNT_W = WAIT_CNT_W
) (
    // clock, reset and bus
    input wire logic              ref_clk_i,
    input wire logic              rst_b_i,
    input wire logic              ce_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic              rd_en_i,
    input wire logic [DATA_W-1:0] rd_data_o,
    // watched inputs
    input wire logic              cmd_active_i,
    input wire logic [CNT_W-1:0]  transmit_wait_time_i,
    input wire logic              rf_field_present_i,
    input wire logic              anticoll_active_i,
    input wire logic              passive_mode_i,
    input wire logic              select_or_poll_answered_i,
    input wire logic              auth_success_i,
    input wire logic              reader_card_mode_i,
    input wire logic              i2c_hs_protocol_i,
    // watched outputs
    input wire logic [MODEM_W-1:0] modem_state_code_o,
    input wire logic              cipher_active_o,
    input wire logic              encrypt_en_o,
    input wire logic              target_activated_flag_o,
    input wire logic              i2c_filter_fast_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // cycles spent in transmit wait, saturating
    logic [CNT_W:0] tx_cnt_q;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            tx_cnt_q <= '0;
        else if (ce_i)
            tx_cnt_q <= (modem_state_code_o != CODE_TX_WAIT) ? '0 : (&tx_cnt_q ? tx_cnt_q : tx_cnt_q + 1'b1);
    end

    chk_read_idle_zero: assert property ($past(ce_i) && !$past(rd_en_i) |-> rd_data_o == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_reserved_bits_zero: assert property ($past(rd_en_i) && $past(addr_i) == STATUS_ADDR |-> rd_data_o[5] == 1'b0 && rd_data_o[7] == 1'b0)
        else $error("reserved or clear bit read as one");
    chk_filter_fast_hs: assert property ($past(rst_b_i) && $past(ce_i) && $past(i2c_hs_protocol_i) |-> i2c_filter_fast_o)
        else $error("filter not fast during fast protocol");
    chk_target_field_off: assert property ($past(ce_i) && !$past(rf_field_present_i, 2) |-> !target_activated_flag_o)
        else $error("target flag kept without field");
    chk_target_set_cause: assert property ($rose(target_activated_flag_o) |-> $past(anticoll_active_i && passive_mode_i && select_or_poll_answered_i, 2))
        else $error("target flag set without passive anticollision answer");
    chk_cipher_set_cause: assert property ($rose(cipher_active_o) |-> $past(auth_success_i, 2))
        else $error("cipher flag set without authentication");
    chk_encrypt_follows: assert property ($past(ce_i) |-> encrypt_en_o == (cipher_active_o && $past(reader_card_mode_i)))
        else $error("encryption enable disagrees with cipher flag");
    chk_modem_idle_cmd: assert property ($past(ce_i) && !$past(cmd_active_i) |-> modem_state_code_o == CODE_IDLE)
        else $error("modem not idle without command");
    chk_idle_to_start: assert property ($past(rst_b_i) && $past(ce_i) && $past(cmd_active_i)
                                        && $past(modem_state_code_o) == CODE_IDLE |-> modem_state_code_o == CODE_WAIT_START)
        else $error("modem did not enter start wait");
    chk_tx_wait_min: assert property (modem_state_code_o == CODE_SENDING && $past(modem_state_code_o) == CODE_TX_WAIT
                                      |-> tx_cnt_q >= transmit_wait_time_i)
        else $error("transmit wait shorter than programmed");
endmodule // modem_link_status_chk

bind modem_link_status modem_link_status_chk #(.CNT_W(CNT_W)) chk_u (.ref_clk_i, .rst_b_i, .ce_i, .addr_i, .rd_en_i,
    .rd_data_o, .cmd_active_i, .transmit_wait_time_i, .rf_field_present_i, .anticoll_active_i, .passive_mode_i,
    .select_or_poll_answered_i, .auth_success_i, .reader_card_mode_i, .i2c_hs_protocol_i, .modem_state_code_o,
    .cipher_active_o, .encrypt_en_o, .target_activated_flag_o, .i2c_filter_fast_o);

// ==== sim/modem_link_status_tb.sv ====
module modem_link_status_tb
    import modem_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_b_i = 0, ce_i = 1, wr_en_i = 0, rd_en_i = 0, cmd_active_i = 0, start_transmit_bit_i = 0;
    logic transmit_wait_for_field_i = 0, receive_wait_for_field_i = 0, tx_done_i = 0, rx_frame_start_i = 0;
    logic rx_done_i = 0, rf_field_present_i = 0, anticoll_active_i = 0, passive_mode_i = 0;
    logic select_or_poll_answered_i = 0, auth_success_i = 0, reader_card_mode_i = 0, temp_over_limit_i = 0;
    logic i2c_hs_protocol_i = 0;
    logic [5:0] addr_i = '0;
    logic [7:0] wr_data_i = '0, transmit_wait_time_i = '0, receive_wait_time_i = '0, rd_data_o, rv;
    logic [2:0] modem_state_code_o;
    logic cipher_active_o, encrypt_en_o, target_activated_flag_o, temp_error_o, i2c_filter_fast_o, irq_o;
    int bad_count = 0, comparisons = 0;
    logic [31:0] seed = 32'h42F8A381;

    always #2.5 ref_clk_i = ~ref_clk_i;

    modem_link_status dut_u (.ref_clk_i, .rst_b_i, .ce_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o,
        .cmd_active_i, .start_transmit_bit_i, .transmit_wait_for_field_i, .receive_wait_for_field_i,
        .transmit_wait_time_i, .receive_wait_time_i, .tx_done_i, .rx_frame_start_i, .rx_done_i, .rf_field_present_i,
        .anticoll_active_i, .passive_mode_i, .select_or_poll_answered_i, .auth_success_i, .reader_card_mode_i,
        .temp_over_limit_i, .i2c_hs_protocol_i, .modem_state_code_o, .cipher_active_o, .encrypt_en_o,
        .target_activated_flag_o, .temp_error_o, .i2c_filter_fast_o, .irq_o);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] exp_status(input logic [7:0] d, input logic t, input logic c);
        return {1'b0, d[6], 1'b0, t, c, CODE_IDLE};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1;
        @(posedge ref_clk_i);
        wr_en_i <= 0;
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_en_i <= 1;
        @(posedge ref_clk_i);
        rd_en_i <= 0;
        #1 d = rd_data_o;
    endtask

    task automatic wait_code(input logic [2:0] c, output int n);
        n = 0;
        #1;
        while (modem_state_code_o !== c && n < 600) begin
            @(posedge ref_clk_i);
            #1 n++;
        end
        chk("modem_code", {5'h00, modem_state_code_o}, {5'h00, c});
        if (modem_state_code_o !== c)
            give_verdict();
    endtask

    task automatic pulse_tgt(input logic a, input logic p);
        @(posedge ref_clk_i);
        rf_field_present_i <= 1;
        anticoll_active_i <= a;
        passive_mode_i <= p;
        select_or_poll_answered_i <= 1;
        @(posedge ref_clk_i);
        select_or_poll_answered_i <= 0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        int n;
        logic [7:0] t;
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1;
        rd(STATUS_ADDR, d);
        chk("status_reset", d, STATUS_RESET);
        rd(IRQ_MASK_ADDR, d);
        chk("irq_mask_reset", d, IRQ_RESET);
        rd(6'h3F, d);
        chk("unmapped", d, UNMAPPED_DATA);
        repeat (4) begin
            rv = xs();
            wr(STATUS_ADDR, rv);
            rd(STATUS_ADDR, d);
            chk("status_rw", d, exp_status(rv, 1'b0, 1'b0));
            chk("filter_force", {7'h00, i2c_filter_fast_o}, {7'h00, rv[6]});
        end
        @(posedge ref_clk_i);
        ce_i <= 0;
        wr(STATUS_ADDR, {1'b0, ~rv[6], 6'h00});
        ce_i <= 1;
        rd(STATUS_ADDR, d);
        chk("ce_frozen", d, exp_status(rv, 1'b0, 1'b0));
        wr(STATUS_ADDR, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk_i);
            i2c_hs_protocol_i <= i[0];
            repeat (2) @(posedge ref_clk_i);
            #1 chk("filter_follow", {7'h00, i2c_filter_fast_o}, {7'h00, i[0]});
        end
        for (int i = 1; i < 4; i++) begin
            pulse_tgt(i[1], i[0]);
            rd(STATUS_ADDR, d);
            chk("target_flag", {7'h00, d[TARGET_BIT]}, {7'h00, i == 3});
        end
        rd(STATUS_ADDR, d);
        chk("target_reread", d, 8'h10);
        chk("target_port", {7'h00, target_activated_flag_o}, 8'h01);
        rd(IRQ_STATUS_ADDR, d);
        chk("irq_target", {7'h00, d[IRQ_TARGET_BIT]}, 8'h01);
        chk("irq_masked", {7'h00, irq_o}, 8'h00);
        wr(IRQ_MASK_ADDR, 8'h01);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("irq_raised", {7'h00, irq_o}, 8'h01);
        wr(IRQ_STATUS_ADDR, 8'h01);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("irq_cleared", {7'h00, irq_o}, 8'h00);
        @(posedge ref_clk_i);
        rf_field_present_i <= 0;
        rd(STATUS_ADDR, d);
        chk("target_field_off", {7'h00, d[TARGET_BIT]}, 8'h00);
        @(posedge ref_clk_i);
        reader_card_mode_i <= 1;
        auth_success_i <= 1;
        @(posedge ref_clk_i);
        auth_success_i <= 0;
        rd(STATUS_ADDR, d);
        chk("cipher_set", {7'h00, d[CIPHER_BIT]}, 8'h01);
        chk("encrypt_on", {7'h00, encrypt_en_o}, 8'h01);
        @(posedge ref_clk_i);
        reader_card_mode_i <= 0;
        repeat (2) @(posedge ref_clk_i);
        #1 chk("encrypt_off", {7'h00, encrypt_en_o}, 8'h00);
        wr(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, d);
        chk("cipher_sw_clear", {7'h00, d[CIPHER_BIT]}, 8'h00);
        wr(STATUS_ADDR, 8'h08);
        rd(STATUS_ADDR, d);
        chk("cipher_sw_set", {7'h00, d[CIPHER_BIT]}, 8'h00);
        @(posedge ref_clk_i);
        temp_over_limit_i <= 1;
        wr(STATUS_ADDR, 8'h80);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("temp_hot_clear", {7'h00, temp_error_o}, 8'h01);
        @(posedge ref_clk_i);
        temp_over_limit_i <= 0;
        wr(STATUS_ADDR, 8'h80);
        repeat (2) @(posedge ref_clk_i);
        #1 chk("temp_cool_clear", {7'h00, temp_error_o}, 8'h00);
        repeat (4) begin
            rv = xs();
            t = {4'h0, rv[3:0]};
            @(posedge ref_clk_i);
            transmit_wait_time_i <= t;
            receive_wait_time_i <= t;
            transmit_wait_for_field_i <= rv[4];
            receive_wait_for_field_i <= rv[5];
            rf_field_present_i <= ~rv[4];
            cmd_active_i <= 1;
            wait_code(CODE_WAIT_START, n);
            @(posedge ref_clk_i);
            start_transmit_bit_i <= 1;
            wait_code(CODE_TX_WAIT, n);
            if (rv[4]) begin
                repeat (t + 3) @(posedge ref_clk_i);
                rd(STATUS_ADDR, d);
                chk("tx_wait_field", {5'h00, d[2:0]}, {5'h00, CODE_TX_WAIT});
                rf_field_present_i <= 1;
            end
            wait_code(CODE_SENDING, n);
            if (!rv[4])
                chk("tx_wait_len", 8'(n), t + 8'h01);
            @(posedge ref_clk_i);
            start_transmit_bit_i <= 0;
            tx_done_i <= 1;
            rf_field_present_i <= ~rv[5];
            @(posedge ref_clk_i);
            tx_done_i <= 0;
            wait_code(CODE_RX_WAIT, n);
            if (rv[5]) begin
                repeat (t + 3) @(posedge ref_clk_i);
                #1 chk("rx_wait_field", {5'h00, modem_state_code_o}, {5'h00, CODE_RX_WAIT});
                rf_field_present_i <= 1;
            end
            wait_code(CODE_WAIT_DATA, n);
            if (!rv[5])
                chk("rx_wait_len", 8'(n), t + 8'h01);
            @(posedge ref_clk_i);
            rx_frame_start_i <= 1;
            @(posedge ref_clk_i);
            rx_frame_start_i <= 0;
            wait_code(CODE_RECEIVING, n);
            @(posedge ref_clk_i);
            rx_done_i <= 1;
            @(posedge ref_clk_i);
            rx_done_i <= 0;
            wait_code(CODE_WAIT_START, n);
            @(posedge ref_clk_i);
            cmd_active_i <= 0;
            wait_code(CODE_IDLE, n);
        end
        rd(IRQ_STATUS_ADDR, d);
        chk("irq_idle", {7'h00, d[IRQ_IDLE_BIT]}, 8'h01);
        give_verdict();
    end
endmodule // modem_link_status_tb
